// file: rtl/dcr_top.sv
// calibration and reference register group with coefficient sequencer
`default_nettype none
module dcr_top #(
  parameter logic [3:0]                 HW_REVISION = 4'h5,  // arbitrary value
  parameter logic [dcr_pkg::COEF_W-1:0] COEF_COEFFICIENT_DEFAULT_RESTORE  = 6'h20
) (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       nrst,
  // register access from the serial port controller
  input  wire logic                       regWrEn,
  input  wire logic                       regRdEn,
  input  wire logic [dcr_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [dcr_pkg::DATA_W-1:0] regWrData,
  output logic      [dcr_pkg::DATA_W-1:0] regRdData,
  // calibration measurement
  input  wire logic [dcr_pkg::COEF_W-1:0] calMeasure,
  // control outputs
  output logic                            externalReferenceSelect,
  output logic                            calClockEnable,
  output logic                            calClockTick,
  output logic                            calBusy,
  output logic      [dcr_pkg::DATA_W-1:0] spiCtlBits,
  output logic      [dcr_pkg::DATA_W-1:0] dataCtlBits
);
  // ****************************************
  // state
  // ****************************************
  logic [dcr_pkg::DATA_W-1:0]   ctl_ff, dataReg_ff, rdData_ff;
  logic [dcr_pkg::COEF_W-1:0]   coefAddr_ff, coefData_ff, walk_ff;
  logic [dcr_pkg::DIVSEL_W-1:0] divSel_ff;
  logic [dcr_pkg::DIVCNT_W-1:0] divCnt_ff, nxt_divCnt, divLim;
  logic [1:0]                   calState_ff, nxt_calState;
  logic                         done_ff, nxt_done, rdPend_ff;
  dcr_pkg::dcr_seq_t            seq_ff, nxt_seq;
  dcr_mem_if                    memBus ();

  function automatic logic [dcr_pkg::DIVCNT_W-1:0] divLimit(input logic [2:0] sel);
    divLimit = dcr_pkg::DIVCNT_W'((dcr_pkg::DIV_BASE >> sel) - dcr_pkg::DIV_ONE);
  endfunction

  // ****************************************
  // decode
  // ****************************************
  wire idle      = (seq_ff == dcr_pkg::SEQ_IDLE);
  wire wrCtl     = regWrEn && (regAddr == dcr_pkg::ADDR_SPI_CTL);
  wire wrData    = regWrEn && (regAddr == dcr_pkg::ADDR_DATA);
  wire wrCalMem  = regWrEn && (regAddr == dcr_pkg::ADDR_CALIBRATION_STATE_AND_DIVIDER);
  wire wrMemCtl  = regWrEn && (regAddr == dcr_pkg::ADDR_MEMCTL);
  wire wrAddr    = regWrEn && (regAddr == dcr_pkg::ADDR_COEF_ADDR);
  wire wrCoef    = regWrEn && (regAddr == dcr_pkg::ADDR_COEF_DATA);
  wire swReset   = wrCtl && regWrData[dcr_pkg::CTL_SOFTWARE_RESET_BIT_BIT];
  // commands are ignored while a walk runs; restore beats start beats write beats read
  wire restoreReq = wrMemCtl && idle && regWrData[dcr_pkg::MC_RESTORE_BIT];
  wire startReq   = wrMemCtl && idle && !restoreReq && regWrData[dcr_pkg::MC_START_BIT];
  wire userWrReq  = wrMemCtl && idle && !restoreReq && !startReq
                    && regWrData[dcr_pkg::MC_WR_BIT];
  wire userRdReq  = wrMemCtl && idle && !restoreReq && !startReq && !userWrReq
                    && regWrData[dcr_pkg::MC_RD_BIT];
  wire lastStep   = (walk_ff == dcr_pkg::COEF_LAST);
  wire calStep    = (seq_ff == dcr_pkg::SEQ_CAL) && calClockTick;
  wire calFinish  = calStep && lastStep;
  wire restStep   = (seq_ff == dcr_pkg::SEQ_RESTORE);

  // ****************************************
  // calibration clock divider
  // ****************************************
  assign divLim       = divLimit(divSel_ff);
  assign calClockEnable = dataReg_ff[dcr_pkg::DATA_CAL_CLOCK_ENABLE_BIT];
  // >= guards a select change that drops the limit below the running count
  assign calClockTick = calClockEnable && (divCnt_ff >= divLim);
  assign nxt_divCnt   = (!calClockEnable || calClockTick) ? '0
                        : dcr_pkg::DIVCNT_W'(divCnt_ff + 1'b1);

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    nxt_seq = seq_ff;
    case (seq_ff)
      dcr_pkg::SEQ_IDLE: begin
        if (restoreReq) begin
          nxt_seq = dcr_pkg::SEQ_RESTORE;
        end else if (startReq) begin
          nxt_seq = dcr_pkg::SEQ_CAL;
        end
      end
      dcr_pkg::SEQ_CAL: begin
        if (calFinish) begin
          nxt_seq = dcr_pkg::SEQ_IDLE;
        end
      end
      dcr_pkg::SEQ_RESTORE: begin
        if (lastStep) begin
          nxt_seq = dcr_pkg::SEQ_IDLE;
        end
      end
      default: begin
        nxt_seq = dcr_pkg::SEQ_IDLE;
      end
    endcase
    if (swReset) begin
      nxt_seq = dcr_pkg::SEQ_IDLE;
    end
  end

  // set wins over any clear
  assign nxt_done = calFinish ? 1'b1 : (swReset || startReq || restoreReq) ? 1'b0 : done_ff;

  always_comb begin
    nxt_calState = calState_ff;
    if (swReset || restoreReq) begin
      nxt_calState = dcr_pkg::CALST_COEFFICIENT_DEFAULT_RESTORE;
    end else if (calFinish) begin
      nxt_calState = dcr_pkg::CALST_SELF;
    end else if (userWrReq) begin
      nxt_calState = dcr_pkg::CALST_USER;
    end
  end

  // ****************************************
  // memory port
  // ****************************************
  assign memBus.we    = calStep || restStep || userWrReq;
  assign memBus.re    = userRdReq;
  assign memBus.addr  = idle ? coefAddr_ff : walk_ff;
  assign memBus.wdata = (seq_ff == dcr_pkg::SEQ_CAL) ? calMeasure
                        : restStep ? COEF_COEFFICIENT_DEFAULT_RESTORE : coefData_ff;

  dcr_coef_mem u_dcr_coef_mem (
    .mclk    (mclk),
    .nrst    (nrst),
    .memPort (memBus.mem)
  );

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seq_ff      <= dcr_pkg::SEQ_IDLE;
      walk_ff     <= '0;
      done_ff     <= 1'b0;
      calState_ff <= dcr_pkg::CALST_COEFFICIENT_DEFAULT_RESTORE;
      divCnt_ff   <= '0;
      rdPend_ff   <= 1'b0;
    end else begin
      seq_ff      <= nxt_seq;
      walk_ff     <= (startReq || restoreReq) ? '0
                     : (calStep || restStep) ? dcr_pkg::COEF_W'(walk_ff + 1'b1) : walk_ff;
      done_ff     <= nxt_done;
      calState_ff <= nxt_calState;
      divCnt_ff   <= nxt_divCnt;
      rdPend_ff   <= userRdReq;
    end
  end

  // control register 0x00 survives software reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctl_ff <= dcr_pkg::CTL_RESET;
    end else if (wrCtl) begin
      ctl_ff <= regWrData & dcr_pkg::CTL_WMASK;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dataReg_ff  <= dcr_pkg::DATA_RESET;
      divSel_ff   <= dcr_pkg::DIVSEL_RESET;
      coefAddr_ff <= dcr_pkg::COEF_ADDR_RESET;
      coefData_ff <= dcr_pkg::COEF_DATA_RESET;
    end else if (swReset) begin
      dataReg_ff  <= dcr_pkg::DATA_RESET;
      divSel_ff   <= dcr_pkg::DIVSEL_RESET;
      coefAddr_ff <= dcr_pkg::COEF_ADDR_RESET;
      coefData_ff <= dcr_pkg::COEF_DATA_RESET;
    end else begin
      if (wrData) dataReg_ff <= regWrData & dcr_pkg::DATA_WMASK;
      if (wrCalMem) divSel_ff <= regWrData[dcr_pkg::DIVSEL_W-1:0];
      if (wrAddr) coefAddr_ff <= regWrData[dcr_pkg::COEF_W-1:0];
      if (wrCoef) begin
        coefData_ff <= regWrData[dcr_pkg::COEF_W-1:0];
      end else if (rdPend_ff) begin
        coefData_ff <= memBus.rdata;
      end
    end
  end

  // ****************************************
  // read back
  // ****************************************
  function automatic logic [7:0] regRead(input logic [4:0] a);
    case (a)
      dcr_pkg::ADDR_SPI_CTL:   regRead = ctl_ff;
      dcr_pkg::ADDR_DATA:      regRead = dataReg_ff;
      dcr_pkg::ADDR_VERSION:   regRead = {4'h0, HW_REVISION};
      dcr_pkg::ADDR_CALIBRATION_STATE_AND_DIVIDER:    regRead = {2'h0, calState_ff, 1'b0, divSel_ff};
      dcr_pkg::ADDR_MEMCTL:    regRead = {done_ff, seq_ff == dcr_pkg::SEQ_CAL, 6'h00};
      dcr_pkg::ADDR_COEF_ADDR: regRead = {2'h0, coefAddr_ff};
      dcr_pkg::ADDR_COEF_DATA: regRead = {2'h0, coefData_ff};
      default:                 regRead = 8'h00;
    endcase
  endfunction

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdData_ff <= 8'h00;
    end else if (regRdEn) begin
      rdData_ff <= regRead(regAddr);
    end
  end

  assign regRdData               = rdData_ff;
  assign externalReferenceSelect = ctl_ff[dcr_pkg::CTL_EXTERNAL_REFERENCE_SELECT_BIT];
  assign calBusy                 = !idle;
  assign spiCtlBits              = ctl_ff;
  assign dataCtlBits             = dataReg_ff;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_div_period:
    assert property (calClockTick |=> !calClockTick)
    else $error("divider ticks back to back");
  a_done_sets:
    assert property (calFinish |=> done_ff && calState_ff == dcr_pkg::CALST_SELF)
    else $error("done flag not set after calibration");
  a_start_runs:
    assert property (startReq && !swReset |=> seq_ff == dcr_pkg::SEQ_CAL && walk_ff == 6'h00)
    else $error("calibration did not start");
  a_coef_write:
    assert property (userWrReq |-> memBus.we && memBus.addr == coefAddr_ff
                     && memBus.wdata == coefData_ff)
    else $error("coefficient write missing");
  a_coef_read:
    assert property (userRdReq ##1 !wrCoef && !swReset |=> coefData_ff == $past(memBus.rdata))
    else $error("coefficient read not returned");
  a_restore_walk:
    assert property (restoreReq && !swReset |=> restStep [*8])
    else $error("restore walk stalled");
  a_restore_end:
    assert property (restoreReq && !swReset |-> ##64 !idle ##1 idle)
    else $error("restore walk length wrong");
  a_software_reset_bit_keep:
    assert property (swReset |=> coefAddr_ff == 6'h00 && coefData_ff == 6'h3F
                     && divSel_ff == 3'h0 && ctl_ff == $past(regWrData & 8'hDF))
    else $error("software reset defaults wrong");
  a_ref_select:
    assert property (wrCtl |=> externalReferenceSelect == $past(regWrData[0]))
    else $error("reference select not updated");
  a_version_ro:
    assert property (regRdEn && regAddr == dcr_pkg::ADDR_VERSION |=> regRdData[3:0] == HW_REVISION)
    else $error("version field wrong");
  a_gate_off:
    assert property (!calClockEnable |-> !calClockTick ##1 divCnt_ff == 8'h00)
    else $error("calibration clock not gated");

  c_cal_done:  cover property (calFinish);
  c_restore:   cover property (restoreReq ##65 idle);
  c_user_read: cover property (userRdReq ##2 regRdEn);
endmodule
`default_nettype wire

// file: common/dcr_pkg.sv
// constants and types of the calibration register group
`default_nettype none
package dcr_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int ADDR_W  = 5;
  localparam int DATA_W  = 8;
  localparam int COEF_W  = 6;
  localparam int DEPTH   = 64;
  localparam int DIVSEL_W = 3;
  localparam int DIVCNT_W = 8;
  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [ADDR_W-1:0] ADDR_SPI_CTL   = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_DATA      = 5'h02;
  localparam logic [ADDR_W-1:0] ADDR_VERSION   = 5'h0D;
  localparam logic [ADDR_W-1:0] ADDR_CALIBRATION_STATE_AND_DIVIDER    = 5'h0E;
  localparam logic [ADDR_W-1:0] ADDR_MEMCTL    = 5'h0F;
  localparam logic [ADDR_W-1:0] ADDR_COEF_ADDR = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_COEF_DATA = 5'h11;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CTL_EXTERNAL_REFERENCE_SELECT_BIT  = 0;
  localparam int CTL_SOFTWARE_RESET_BIT_BIT  = 5;
  localparam int DATA_CAL_CLOCK_ENABLE_BIT = 0;
  localparam int CALST_LSB      = 4;
  localparam int MC_DONE_BIT    = 7;
  localparam int MC_START_BIT   = 6;
  localparam int MC_WR_BIT      = 3;
  localparam int MC_RD_BIT      = 2;
  localparam int MC_RESTORE_BIT = 0;
  // ****************************************
  // reset values and masks
  // ****************************************
  localparam logic [DATA_W-1:0] CTL_RESET  = 8'h80;
  localparam logic [DATA_W-1:0] CTL_WMASK  = 8'hDF;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_WMASK = 8'h9D;
  localparam logic [COEF_W-1:0] COEF_ADDR_RESET = 6'h00;
  localparam logic [COEF_W-1:0] COEF_DATA_RESET = 6'h3F;
  localparam logic [COEF_W-1:0] COEF_LAST  = 6'h3F;
  localparam logic [DIVSEL_W-1:0] DIVSEL_RESET = 3'h0;
  localparam logic [8:0] DIV_BASE = 9'h100;
  localparam logic [8:0] DIV_ONE  = 9'h001;
  // ****************************************
  // calibration state field codes
  // ****************************************
  localparam logic [1:0] CALST_COEFFICIENT_DEFAULT_RESTORE = 2'h0;
  localparam logic [1:0] CALST_SELF  = 2'h1;
  localparam logic [1:0] CALST_USER  = 2'h3;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_CAL, SEQ_RESTORE} dcr_seq_t;
endpackage
`default_nettype wire

// file: common/dcr_mem_if.sv
// coefficient memory port between sequencer and storage
`default_nettype none
interface dcr_mem_if;
  logic                       we;
  logic                       re;
  logic [dcr_pkg::COEF_W-1:0] addr;
  logic [dcr_pkg::COEF_W-1:0] wdata;
  logic [dcr_pkg::COEF_W-1:0] rdata;
  modport ctrl (output we, output re, output addr, output wdata, input rdata);
  modport mem  (input we, input re, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: rtl/dcr_coef_mem.sv
// static coefficient memory, registered read data
`default_nettype none
module dcr_coef_mem (
  // clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // access port
  dcr_mem_if.mem    memPort
);
  logic [dcr_pkg::COEF_W-1:0] store [dcr_pkg::DEPTH];
  logic [dcr_pkg::COEF_W-1:0] rdata_ff;

  // storage has no reset: contents only change by user write, calibration walk or restore walk
  always_ff @(posedge mclk) begin
    if (memPort.we) begin
      store[memPort.addr] <= memPort.wdata;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= '0;
    end else if (memPort.re) begin
      rdata_ff <= store[memPort.addr];
    end
  end

  assign memPort.rdata = rdata_ff;
endmodule
`default_nettype wire

// file: dv/dcr_host_model.sv
// register bus host model that configures the calibration register group
`default_nettype none
module dcr_host_model (
  // clock
  input  wire logic                       mclk,
  // register bus toward the device
  output logic                            regWrEn,
  output logic                            regRdEn,
  output logic      [dcr_pkg::ADDR_W-1:0] regAddr,
  output logic      [dcr_pkg::DATA_W-1:0] regWrData,
  input  wire logic [dcr_pkg::DATA_W-1:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // bus cycles
  // ****************************************
  initial begin
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regAddr   = '0;
    regWrData = '0;
  end
  // released lines show the inverse so a stale value never reads as valid
  task automatic write_reg(input logic [dcr_pkg::ADDR_W-1:0] a,
                           input logic [dcr_pkg::DATA_W-1:0] d);
    @(posedge mclk);
    regWrEn   <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge mclk);
    regWrEn   <= 1'b0;
    regAddr   <= ~a;
    regWrData <= ~d;
  endtask
  task automatic read_reg(input logic [dcr_pkg::ADDR_W-1:0] a,
                          output logic [dcr_pkg::DATA_W-1:0] d);
    @(posedge mclk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    @(negedge mclk);
    d = regRdData;
  endtask
endmodule
`default_nettype wire

// file: dv/test_dac_calibration_registers.sv
// self-checking bench for the calibration register group
`default_nettype none
module test_dac_calibration_registers;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] HW_REV = 4'hA;  // arbitrary value
  localparam logic [5:0] COEFFICIENT_DEFAULT_RESTORE  = 6'h15;
  logic       mclk;
  logic       nrst;
  logic [5:0] calMeasure;
  logic       wrEn;
  logic       rdEn;
  logic [4:0] addr;
  logic [7:0] wrData;
  logic [7:0] rdData;
  logic       extRef;
  logic       clkEn;
  logic       tick;
  logic       busy;
  logic [7:0] spiBits;
  logic [7:0] dataBits;
  int         fail_count;
  int         cmp_count;
  int         cycles;
  int         n;
  int         s;
  logic [7:0] v;
  logic [5:0] calBase;
  dcr_top #(.HW_REVISION(HW_REV), .COEF_COEFFICIENT_DEFAULT_RESTORE(COEFFICIENT_DEFAULT_RESTORE)) u_dcr_top (
    .mclk(mclk), .nrst(nrst), .regWrEn(wrEn), .regRdEn(rdEn), .regAddr(addr),
    .regWrData(wrData), .regRdData(rdData), .calMeasure(calMeasure),
    .externalReferenceSelect(extRef), .calClockEnable(clkEn), .calClockTick(tick),
    .calBusy(busy), .spiCtlBits(spiBits), .dataCtlBits(dataBits));
  dcr_host_model u_dcr_host_model (
    .mclk(mclk), .regWrEn(wrEn), .regRdEn(rdEn), .regAddr(addr),
    .regWrData(wrData), .regRdData(rdData));
  // ****************************************
  // checks and helpers
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_dcr_host_model.write_reg(a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    u_dcr_host_model.read_reg(a, v);
    chk({8'h00, v}, {8'h00, e});
  endtask
  task automatic coef_wr(input logic [5:0] a, input logic [5:0] d);
    wr(5'h10, {2'b00, a});
    wr(5'h11, {2'b00, d});
    wr(5'h0F, 8'h08);
  endtask
  task automatic coef_rd(input logic [5:0] a, input logic [5:0] e);
    wr(5'h10, {2'b00, a});
    wr(5'h0F, 8'h04);
    repeat (3) @(posedge mclk);
    rd(5'h11, {2'b00, e});
  endtask
  task automatic tick_period(output int p);
    int i;
    p = 0;
    for (i = 0; i < 600 && tick !== 1'b1; i++) @(negedge mclk);
    @(negedge mclk);
    p = 1;
    while (tick !== 1'b1 && p < 600) begin
      @(negedge mclk);
      p++;
    end
  endtask
  task automatic wait_idle();
    int i;
    @(negedge mclk);
    for (i = 0; i < 400 && busy === 1'b1; i++) @(negedge mclk);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;
  // a fresh measurement per calibration step, so a misplaced step shows up
  always @(posedge mclk) begin
    if (nrst !== 1'b1) calMeasure <= 6'h2C;
    else if (busy === 1'b1 && tick === 1'b1) calMeasure <= calMeasure + 6'h01;
  end
  initial cycles = 0;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      test_done();
    end
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    nrst = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    rd(5'h0D, {4'h0, HW_REV});
    rd(5'h0E, 8'h00);
    rd(5'h0F, 8'h00);
    rd(5'h10, 8'h00);
    rd(5'h11, 8'h3F);
    rd(5'h05, 8'h00);
    chk({15'h0, extRef}, 16'h0);
    wr(5'h0D, 8'hFF);
    rd(5'h0D, {4'h0, HW_REV});
    $display("test reset_values done");
    wr(5'h00, 8'h81);
    @(negedge mclk);
    chk({15'h0, extRef}, 16'h1);
    chk({8'h0, spiBits}, 16'h81);
    wr(5'h00, 8'h80);
    @(negedge mclk);
    chk({15'h0, extRef}, 16'h0);
    $display("test reference done");
    for (s = 0; s < 300; s++) begin
      @(negedge mclk);
      if (tick === 1'b1) chk(16'h1, 16'h0);
    end
    wr(5'h02, 8'h01);
    @(negedge mclk);
    chk({15'h0, clkEn}, 16'h1);
    chk({8'h0, dataBits}, 16'h01);
    for (s = 0; s < 8; s++) begin
      wr(5'h0E, s[7:0]);
      tick_period(n);
      tick_period(n);
      chk(n[15:0], 16'd256 >> s);
    end
    $display("test divider done");
    coef_wr(6'h3F, 6'h2A);
    coef_wr(6'h00, 6'h15);
    rd(5'h0E, 8'h37);
    wr(5'h11, 8'h00);
    coef_rd(6'h3F, 6'h2A);
    coef_rd(6'h00, 6'h15);
    coef_wr(6'h00, 6'h01);
    coef_rd(6'h00, 6'h01);
    $display("test coefficient_access done");
    wr(5'h0F, 8'h01);
    wait_idle();
    chk({15'h0, busy}, 16'h0);
    rd(5'h0E, 8'h07);
    coef_rd(6'h00, COEFFICIENT_DEFAULT_RESTORE);
    coef_rd(6'h3F, COEFFICIENT_DEFAULT_RESTORE);
    $display("test restore done");
    calBase = calMeasure;
    wr(5'h0F, 8'h40);
    rd(5'h0F, 8'h40);
    wait_idle();
    rd(5'h0F, 8'h80);
    rd(5'h0E, 8'h17);
    coef_rd(6'h00, calBase);
    coef_rd(6'h3F, calBase + 6'h3F);
    $display("test calibration done");
    wr(5'h11, 8'h2C);
    wr(5'h00, 8'hA1);
    rd(5'h00, 8'h81);
    rd(5'h02, 8'h00);
    rd(5'h0E, 8'h00);
    rd(5'h0F, 8'h00);
    rd(5'h10, 8'h00);
    rd(5'h11, 8'h3F);
    chk({14'h0, extRef, clkEn}, 16'h2);
    chk({8'h0, spiBits}, 16'h81);
    chk({8'h0, dataBits}, 16'h00);
    $display("test software_reset done");
    test_done();
  end
endmodule
`default_nettype wire
